// ### design/paging_pkg.sv
`default_nettype none
package paging_pkg;
	localparam int ADDR_W = 18;
	localparam int WORD_W = 24;
	localparam int PAGE_W = 8;
	localparam int OFFSET_W = 10;
	localparam int ENTRY_W = 10;
	localparam int PTR_W = 12;
	localparam int LIMIT_W = 10;
	localparam int FAULT_W = 12;
	// Map size: 256, 1024 or 4096 entries; this build carries 256
	localparam int MAP_ENTRIES = 256;
	localparam int MAP_IDX_W = 8;
	// Field positions
	localparam int ENTRY_MODE_LSB = 8;
	localparam int LIMIT_ROM_BIT = 8;
	localparam int LIMIT_PRIV_BIT = 9;
	localparam int FAULT_PAGE_LSB = 4;
	localparam int DIRECT_FIELD_W = 15;
	// Reset values
	localparam logic [PTR_W-1:0] BASE_RESET = 12'h000;
	localparam logic [LIMIT_W-1:0] LIMIT_RESET = 10'h000;
	localparam logic [PTR_W-1:0] PTR_RESET = 12'h000;
	localparam logic [FAULT_W-1:0] FAULT_RESET = 12'h000;
	localparam logic [ENTRY_W-1:0] ENTRY_RESET = 10'h000;
	// Upper-half bias for immediate references, 100000 octal
	localparam logic [ADDR_W-1:0] UPPER_HALF_BIAS = 18'h08000;
	// Access mode codes
	localparam logic [1:0] MODE_MISSING = 2'h0;
	localparam logic [1:0] MODE_FREE = 2'h1;
	localparam logic [1:0] MODE_EXEC_READ = 2'h2;
	localparam logic [1:0] MODE_READ_ONLY = 2'h3;
	// Fault codes
	localparam logic [3:0] FC_DEMAND_EXM = 4'h1;
	localparam logic [3:0] FC_DEMAND_MEMREF = 4'h2;
	localparam logic [3:0] FC_DEMAND_RELEASE = 4'h3;
	localparam logic [3:0] FC_MODE3_EXM = 4'h5;
	localparam logic [3:0] FC_MODE3_MEMREF = 4'h5;
	localparam logic [3:0] FC_MODE3_RELEASE = 4'h7;
	localparam logic [3:0] FC_MODE2_EXM = 4'h9;
	localparam logic [3:0] FC_MODE2_MEMREF = 4'hA;
	localparam logic [3:0] FC_MODE2_RELEASE = 4'hB;
	localparam logic [3:0] FC_LIMIT_EXM = 4'hE;
	localparam logic [3:0] FC_LIMIT_MEMREF = 4'hE;
	localparam logic [3:0] FC_LIMIT_RELEASE = 4'hF;

	typedef enum logic [1:0] {ACC_FETCH = 2'h0, ACC_READ = 2'h1, ACC_WRITE = 2'h2} access_type;
	typedef enum logic [1:0] {CAUSE_EXM_BRANCH = 2'h1, CAUSE_MEMREF = 2'h2,
		CAUSE_RELEASE = 2'h3} cause_type;
	typedef enum logic [3:0] {CMD_LOAD_BASE = 4'h0, CMD_READ_BASE = 4'h1, CMD_LOAD_LIMIT = 4'h2,
		CMD_READ_LIMIT = 4'h3, CMD_LOAD_PTRS = 4'h4, CMD_LOAD_WPTR = 4'h5,
		CMD_ACC_TO_MAP = 4'h6, CMD_DOUBLE_TO_PAIR = 4'h7, CMD_PAIR_TO_DOUBLE = 4'h8,
		CMD_READ_FAULT = 4'h9} cmd_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr_field;
		logic immediate;
		logic [1:0] index_sel;
		access_type access;
		cause_type cause;
	} cpu_ref_type;

	typedef struct packed {
		logic [WORD_W-1:0] hi;
		logic [WORD_W-1:0] lo;
	} double_type;
endpackage
`default_nettype wire

// ### design/paged_address_translation.sv
`timescale 1ns/10ps
`default_nettype none
module paged_address_translation (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Processor reference
	input wire logic i_ref_valid,
	input wire paging_pkg::cpu_ref_type i_ref,
	input wire logic i_user_mode,
	input wire logic i_pc_half_select_bit,
	input wire logic [paging_pkg::WORD_W-1:0] i_index_i,
	input wire logic [paging_pkg::WORD_W-1:0] i_index_j,
	input wire logic [paging_pkg::WORD_W-1:0] i_index_k,
	// Paging instructions
	input wire logic i_cmd_valid,
	input wire paging_pkg::cmd_type i_cmd,
	input wire paging_pkg::double_type i_cmd_data,
	output logic o_cmd_done,
	output paging_pkg::double_type o_cmd_data,
	// Physical memory bus
	output logic o_mem_valid,
	output logic [paging_pkg::ADDR_W-1:0] o_mem_addr,
	output logic o_mem_write,
	// Trap and control
	output logic o_trap_l2,
	output logic o_priv_allow,
	output logic o_rom_suppress
);
	import paging_pkg::*;

	logic [PTR_W-1:0] base_reg;
	logic [LIMIT_W-1:0] limit_reg;
	logic [PTR_W-1:0] rptr_reg;
	logic [PTR_W-1:0] wptr_reg;
	logic [FAULT_W-1:0] fault_reg;
	logic [ENTRY_W-1:0] map_reg [MAP_ENTRIES];
	logic cmd_done_reg;
	double_type cmd_data_reg;
	logic mem_valid_reg;
	logic [ADDR_W-1:0] mem_addr_reg;
	logic mem_write_reg;
	logic trap_reg;

	logic [ADDR_W-1:0] index_val;
	logic [ADDR_W-1:0] eff_addr;
	logic [PAGE_W-1:0] log_page;
	logic [PTR_W-1:0] entry_idx;
	logic [ENTRY_W-1:0] entry;
	logic over_limit;
	logic mode_bad;
	logic [3:0] code_next;

	function automatic logic [MAP_IDX_W-1:0] map_index(input logic [PTR_W-1:0] ptr);
		map_index = ptr[MAP_IDX_W-1:0];
	endfunction

	function automatic logic [3:0] fault_code(input logic [1:0] kind, input cause_type c);
		logic [3:0] dem;
		logic [3:0] m3;
		logic [3:0] m2;
		logic [3:0] lim;
		dem = (c == CAUSE_EXM_BRANCH) ? FC_DEMAND_EXM :
			(c == CAUSE_MEMREF) ? FC_DEMAND_MEMREF : FC_DEMAND_RELEASE;
		m3 = (c == CAUSE_EXM_BRANCH) ? FC_MODE3_EXM :
			(c == CAUSE_MEMREF) ? FC_MODE3_MEMREF : FC_MODE3_RELEASE;
		m2 = (c == CAUSE_EXM_BRANCH) ? FC_MODE2_EXM :
			(c == CAUSE_MEMREF) ? FC_MODE2_MEMREF : FC_MODE2_RELEASE;
		lim = (c == CAUSE_EXM_BRANCH) ? FC_LIMIT_EXM :
			(c == CAUSE_MEMREF) ? FC_LIMIT_MEMREF : FC_LIMIT_RELEASE;
		case (kind)
			2'h0: fault_code = dem;
			2'h1: fault_code = m3;
			2'h2: fault_code = m2;
			default: fault_code = lim;
		endcase
	endfunction

	// Effective address formation
	always_comb begin
		case (i_ref.index_sel)
			2'h1: index_val = i_index_i[ADDR_W-1:0];
			2'h2: index_val = i_index_j[ADDR_W-1:0];
			2'h3: index_val = i_index_k[ADDR_W-1:0];
			default: index_val = '0;
		endcase
		eff_addr = i_ref.addr_field;
		if (i_ref.immediate) begin
			eff_addr = {3'h0, i_ref.addr_field[DIRECT_FIELD_W-1:0]};
			if (i_pc_half_select_bit) begin
				eff_addr = eff_addr | UPPER_HALF_BIAS;
			end
		end
		eff_addr = ADDR_W'(eff_addr + index_val);
	end

	// Translation and checks
	always_comb begin
		log_page = eff_addr[ADDR_W-1:OFFSET_W];
		entry_idx = PTR_W'(base_reg + {4'h0, log_page});
		entry = map_reg[map_index(entry_idx)];
		over_limit = log_page > limit_reg[PAGE_W-1:0];
		mode_bad = 1'b0;
		case (entry[ENTRY_W-1:ENTRY_MODE_LSB])
			MODE_FREE: mode_bad = 1'b0;
			MODE_EXEC_READ: mode_bad = (i_ref.access == ACC_WRITE);
			MODE_READ_ONLY: mode_bad = (i_ref.access != ACC_READ);
			default: mode_bad = 1'b0;
		endcase
		if (over_limit) begin
			code_next = fault_code(2'h3, i_ref.cause);
		end else if (entry[ENTRY_W-1:ENTRY_MODE_LSB] == MODE_MISSING) begin
			code_next = fault_code(2'h0, i_ref.cause);
		end else if (entry[ENTRY_W-1:ENTRY_MODE_LSB] == MODE_READ_ONLY) begin
			code_next = fault_code(2'h1, i_ref.cause);
		end else begin
			code_next = fault_code(2'h2, i_ref.cause);
		end
	end

	// Memory request and trap
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			mem_valid_reg <= 1'b0;
			mem_addr_reg <= '0;
			mem_write_reg <= 1'b0;
			trap_reg <= 1'b0;
		end else begin
			mem_valid_reg <= 1'b0;
			trap_reg <= 1'b0;
			if (i_ref_valid) begin
				mem_write_reg <= (i_ref.access == ACC_WRITE);
				if (!i_user_mode) begin
					mem_valid_reg <= 1'b1;
					mem_addr_reg <= eff_addr;
				end else if (over_limit || mode_bad ||
					entry[ENTRY_W-1:ENTRY_MODE_LSB] == MODE_MISSING) begin
					trap_reg <= 1'b1;
				end else begin
					mem_valid_reg <= 1'b1;
					mem_addr_reg <= {entry[PAGE_W-1:0], eff_addr[OFFSET_W-1:0]};
				end
			end
		end
	end

	// Fault register
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			fault_reg <= FAULT_RESET;
		end else if (i_ref_valid && i_user_mode) begin
			fault_reg[FAULT_W-1:FAULT_PAGE_LSB] <= log_page;
			if (over_limit || mode_bad || entry[ENTRY_W-1:ENTRY_MODE_LSB] == MODE_MISSING) begin
				fault_reg[FAULT_PAGE_LSB-1:0] <= code_next;
			end
		end
	end

	// Control registers
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			base_reg <= BASE_RESET;
			limit_reg <= LIMIT_RESET;
			rptr_reg <= PTR_RESET;
			wptr_reg <= PTR_RESET;
		end else if (i_cmd_valid) begin
			case (i_cmd)
				CMD_LOAD_BASE: base_reg <= i_cmd_data.lo[PTR_W-1:0];
				CMD_LOAD_LIMIT: limit_reg <= i_cmd_data.lo[LIMIT_W-1:0];
				CMD_LOAD_PTRS: begin
					rptr_reg <= i_cmd_data.hi[PTR_W-1:0];
					wptr_reg <= i_cmd_data.lo[PTR_W-1:0];
				end
				CMD_LOAD_WPTR: wptr_reg <= i_cmd_data.lo[PTR_W-1:0];
				default: base_reg <= base_reg;
			endcase
		end
	end

	// Page map storage
	generate
		for (genvar g = 0; g < MAP_ENTRIES; g++) begin : g_map
			always_ff @(posedge i_mclk) begin
				if (!i_rst_b) begin
					map_reg[g] <= ENTRY_RESET;
				end else if (i_cmd_valid && (i_cmd == CMD_ACC_TO_MAP ||
					i_cmd == CMD_DOUBLE_TO_PAIR) && map_index(wptr_reg) == MAP_IDX_W'(g)) begin
					map_reg[g] <= i_cmd_data.lo[ENTRY_W-1:0];
				end else if (i_cmd_valid && i_cmd == CMD_DOUBLE_TO_PAIR &&
					map_index(PTR_W'(wptr_reg + 12'h001)) == MAP_IDX_W'(g)) begin
					map_reg[g] <= i_cmd_data.hi[ENTRY_W-1:0];
				end
			end
		end
	endgenerate

	// Readback
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			cmd_done_reg <= 1'b0;
			cmd_data_reg <= '0;
		end else begin
			cmd_done_reg <= i_cmd_valid;
			if (i_cmd_valid) begin
				cmd_data_reg <= '0;
				case (i_cmd)
					CMD_READ_BASE: cmd_data_reg.lo <= {12'h000, base_reg};
					CMD_READ_LIMIT: cmd_data_reg.lo <= {14'h0000, limit_reg};
					CMD_READ_FAULT: cmd_data_reg.lo <= {12'h000, fault_reg};
					CMD_PAIR_TO_DOUBLE: begin
						cmd_data_reg.lo <= {14'h0000, map_reg[map_index(rptr_reg)]};
						cmd_data_reg.hi <= {14'h0000,
							map_reg[map_index(PTR_W'(rptr_reg + 12'h001))]};
					end
					default: cmd_data_reg <= '0;
				endcase
			end
		end
	end

	assign o_cmd_done = cmd_done_reg;
	assign o_cmd_data = cmd_data_reg;
	assign o_mem_valid = mem_valid_reg;
	assign o_mem_addr = mem_addr_reg;
	assign o_mem_write = mem_write_reg;
	assign o_trap_l2 = trap_reg;
	assign o_priv_allow = limit_reg[LIMIT_PRIV_BIT];
	assign o_rom_suppress = limit_reg[LIMIT_ROM_BIT];

	// Checks on the reference and command paths
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	chk_monitor_bypass: assert property ((i_ref_valid && !i_user_mode) |=>
		(o_mem_valid && o_mem_addr == $past(eff_addr)))
		else $error("monitor reference not passed through");
	chk_index_one: assert property ((i_ref_valid && !i_user_mode && !i_ref.immediate &&
		i_ref.index_sel == 2'h1) |=>
		o_mem_addr == ADDR_W'($past(i_ref.addr_field) + $past(i_index_i[ADDR_W-1:0])))
		else $error("index register not added");
	chk_trap_no_mem: assert property (o_trap_l2 |-> !o_mem_valid)
		else $error("trap and memory request together");
	chk_fault_page: assert property ((i_ref_valid && i_user_mode) |=>
		fault_reg[FAULT_W-1:FAULT_PAGE_LSB] == $past(eff_addr[ADDR_W-1:OFFSET_W]))
		else $error("logical page not recorded");
	chk_limit_trap: assert property ((i_ref_valid && i_user_mode && over_limit) |=>
		(o_trap_l2 && fault_reg[3:2] == 2'h3))
		else $error("limit violation missed");
	chk_demand_code: assert property ((i_ref_valid && i_user_mode && !over_limit &&
		entry[ENTRY_W-1:ENTRY_MODE_LSB] == MODE_MISSING) |=>
		(o_trap_l2 && fault_reg[3:2] == 2'h0 && fault_reg[1:0] != 2'h0))
		else $error("demand page not flagged");
	chk_phys_addr: assert property ((i_ref_valid && i_user_mode && !over_limit &&
		!mode_bad && entry[ENTRY_W-1:ENTRY_MODE_LSB] != MODE_MISSING) |=>
		(o_mem_valid && o_mem_addr == {$past(entry[PAGE_W-1:0]), $past(eff_addr[OFFSET_W-1:0])}))
		else $error("physical address wrong");
	chk_base_load: assert property ((i_cmd_valid && i_cmd == CMD_LOAD_BASE) ##1
		!i_cmd_valid ##1
		(i_cmd_valid && i_cmd == CMD_READ_BASE) |=>
		o_cmd_data.lo[PTR_W-1:0] == $past(i_cmd_data.lo[PTR_W-1:0], 3))
		else $error("base register readback wrong");
	chk_mode_trap: assert property ((i_ref_valid && i_user_mode && !over_limit && mode_bad) |=>
		(o_trap_l2 && !o_mem_valid))
		else $error("access mode violation missed");
	chk_pair_store: assert property ((i_cmd_valid && i_cmd == CMD_DOUBLE_TO_PAIR) |=>
		map_reg[map_index($past(wptr_reg))] == $past(i_cmd_data.lo[ENTRY_W-1:0]))
		else $error("map pair store wrong");
	chk_code_hold: assert property ((i_ref_valid && i_user_mode && !over_limit && !mode_bad &&
		entry[ENTRY_W-1:ENTRY_MODE_LSB] != MODE_MISSING) |=>
		fault_reg[FAULT_PAGE_LSB-1:0] == $past(fault_reg[FAULT_PAGE_LSB-1:0]))
		else $error("fault code changed without fault");
	chk_upper_bias: assert property ((i_ref_valid && !i_user_mode && i_ref.immediate &&
		i_pc_half_select_bit && i_ref.index_sel == 2'h0) |=> o_mem_addr[15])
		else $error("upper half bias missing");
endmodule
`default_nettype wire

// ### test/mem_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module mem_bus_model (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Physical memory bus
	input wire logic i_mem_valid,
	input wire logic [paging_pkg::ADDR_W-1:0] i_mem_addr,
	input wire logic i_mem_write,
	// Observation
	output logic [31:0] o_req_cnt,
	output logic [paging_pkg::ADDR_W-1:0] o_last_addr
);
	import paging_pkg::*;
	// The bus has no back-pressure, so every request is taken on the edge it appears
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_req_cnt <= '0;
			o_last_addr <= '0;
		end else if (i_mem_valid) begin
			o_req_cnt <= o_req_cnt + 32'h1;
			o_last_addr <= i_mem_addr;
		end
	end
endmodule
`default_nettype wire

// ### test/tb_paged_address_translation.sv
`timescale 1ns/10ps
`default_nettype none
module tb_paged_address_translation;
	import paging_pkg::*;
	logic i_mclk, i_rst_b, i_ref_valid, i_user_mode, i_pc_half_select_bit, i_cmd_valid;
	cpu_ref_type i_ref;
	logic [WORD_W-1:0] i_index_i, i_index_j, i_index_k;
	cmd_type i_cmd;
	double_type i_cmd_data, o_cmd_data, d;
	logic o_cmd_done, o_mem_valid, o_mem_write, o_trap_l2, o_priv_allow, o_rom_suppress;
	logic [ADDR_W-1:0] o_mem_addr;
	logic [31:0] req_cnt, mem_cnt;
	int error_cnt, num_checks, seed;
	logic [ENTRY_W-1:0] map [MAP_ENTRIES];
	logic [PTR_W-1:0] base;
	logic [LIMIT_W-1:0] limit;
	logic [FAULT_W-1:0] fault;
	logic [31:0] a;
	cpu_ref_type r;

	paged_address_translation i_paged_address_translation (.i_mclk, .i_rst_b, .i_ref_valid,
		.i_ref, .i_user_mode, .i_pc_half_select_bit, .i_index_i, .i_index_j, .i_index_k,
		.i_cmd_valid, .i_cmd, .i_cmd_data, .o_cmd_done, .o_cmd_data, .o_mem_valid,
		.o_mem_addr, .o_mem_write, .o_trap_l2, .o_priv_allow, .o_rom_suppress);
	mem_bus_model i_mem_bus_model (.i_mclk, .i_rst_b, .i_mem_valid(o_mem_valid),
		.i_mem_addr(o_mem_addr), .i_mem_write(o_mem_write), .o_req_cnt(req_cnt),
		.o_last_addr());

	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end

	task automatic cmp(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		cmp(req_cnt[23:0], mem_cnt[23:0]);
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic cmd(input cmd_type c, input logic [WORD_W-1:0] hi, input logic [WORD_W-1:0] lo);
		@(posedge i_mclk);
		i_cmd_valid <= 1'b1;
		i_cmd <= c;
		i_cmd_data <= {hi, lo};
		@(posedge i_mclk);
		i_cmd_valid <= 1'b0;
		#1;
		cmp(24'(o_cmd_done), 24'h1);
		d = o_cmd_data;
	endtask

	// Fault code from violation kind: 0 demand, 1 mode 3, 2 mode 2, 3 limit
	function automatic logic [3:0] fcode(input int kind, input cause_type c);
		case (kind)
			0: return {2'h0, c};
			1: return (c == CAUSE_RELEASE) ? 4'h7 : 4'h5;
			2: return {2'h2, c};
			default: return (c == CAUSE_RELEASE) ? 4'hF : 4'hE;
		endcase
	endfunction

	task automatic ref_go(input cpu_ref_type rr, input logic user, input logic pc);
		logic [ADDR_W-1:0] ea, ix;
		logic [7:0] pg;
		logic [ENTRY_W-1:0] e;
		logic flt;
		ix = '0;
		if (rr.index_sel == 2'h1) ix = i_index_i[ADDR_W-1:0];
		if (rr.index_sel == 2'h2) ix = i_index_j[ADDR_W-1:0];
		if (rr.index_sel == 2'h3) ix = i_index_k[ADDR_W-1:0];
		ea = rr.addr_field;
		if (rr.immediate) ea = {3'h0, rr.addr_field[14:0]} | (pc ? UPPER_HALF_BIAS : 18'h0);
		ea = ea + ix;
		pg = ea[17:10];
		e = map[8'(base + 12'(pg))];
		flt = 1'b1;
		if (user) begin
			fault[11:4] = pg;
			if (pg > limit[7:0]) fault[3:0] = fcode(3, rr.cause);
			else if (e[9:8] == MODE_MISSING) fault[3:0] = fcode(0, rr.cause);
			else if (e[9:8] == MODE_EXEC_READ && rr.access == ACC_WRITE) fault[3:0] = fcode(2, rr.cause);
			else if (e[9:8] == MODE_READ_ONLY && rr.access != ACC_READ) fault[3:0] = fcode(1, rr.cause);
			else flt = 1'b0;
			ea = {e[7:0], ea[9:0]};
		end else flt = 1'b0;
		@(posedge i_mclk);
		i_ref_valid <= 1'b1;
		i_ref <= rr;
		i_user_mode <= user;
		i_pc_half_select_bit <= pc;
		@(posedge i_mclk);
		i_ref_valid <= 1'b0;
		#1;
		cmp(24'(o_trap_l2), 24'(flt));
		cmp(24'(o_mem_valid), 24'(!flt));
		if (!flt) begin
			cmp(24'(o_mem_addr), 24'(ea));
			cmp(24'(o_mem_write), 24'(rr.access == ACC_WRITE));
			mem_cnt++;
		end
		cmd(CMD_READ_FAULT, '0, '0);
		cmp(d.lo, 24'(fault));
	endtask

	initial begin
		error_cnt = 0;
		num_checks = 0;
		seed = 13;
		mem_cnt = '0;
		fault = '0;
		i_rst_b = 1'b0;
		{i_ref_valid, i_user_mode, i_pc_half_select_bit, i_cmd_valid} = '0;
		i_ref = '0;
		i_cmd = CMD_LOAD_BASE;
		i_cmd_data = '0;
		i_index_i = '0;
		i_index_j = '0;
		i_index_k = '0;
		repeat (12) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		cmd(CMD_READ_FAULT, '0, '0);
		cmp(d.lo, 24'(FAULT_RESET));
		i_index_i <= $random(seed);
		i_index_j <= $random(seed);
		i_index_k <= 24'h03FFFF;
		base = 12'($random(seed));
		cmd(CMD_LOAD_BASE, '0, 24'(base));
		cmd(CMD_READ_BASE, '0, '0);
		cmp(d.lo, 24'(base));
		for (int m = 0; m < 4; m++) begin
			limit = {m[1:0], 8'h80};
			cmd(CMD_LOAD_LIMIT, '0, 24'(limit));
			cmd(CMD_READ_LIMIT, '0, '0);
			cmp(d.lo, 24'(limit));
			cmp(24'(o_priv_allow), 24'(m[1]));
			cmp(24'(o_rom_suppress), 24'(m[0]));
		end
		for (int k = 0; k < MAP_ENTRIES; k += 2) begin
			map[k] = 10'($random(seed));
			map[k+1] = 10'($random(seed));
			cmd(CMD_LOAD_WPTR, '0, 24'(k));
			cmd(CMD_DOUBLE_TO_PAIR, 24'(map[k+1]), 24'(map[k]));
		end
		cmd(CMD_LOAD_WPTR, '0, 24'h000005);
		map[5] = 10'h1A5;
		cmd(CMD_ACC_TO_MAP, '0, 24'(map[5]));
		for (int k = 0; k < 16; k++) begin
			a = $random(seed);
			cmd(CMD_LOAD_PTRS, 24'(a[7:0]), 24'(a[15:8]));
			cmd(CMD_PAIR_TO_DOUBLE, '0, '0);
			cmp(d.lo, 24'(map[a[7:0]]));
			cmp(d.hi, 24'(map[8'(a[7:0] + 8'h1)]));
		end
		repeat (400) begin
			a = $random(seed);
			r.addr_field = 18'($random(seed));
			r.immediate = a[7];
			r.index_sel = a[9:8];
			r.access = access_type'((a[1:0] == 2'h3) ? 2'h1 : a[1:0]);
			r.cause = cause_type'((a[3:2] == 2'h0) ? 2'h2 : a[3:2]);
			ref_go(r, a[4] | a[5], a[6]);
		end
		end_of_test();
	end

	initial begin
		repeat (20000) @(posedge i_mclk);
		error_cnt++;
		end_of_test();
	end
endmodule
`default_nettype wire
